// ### dv/flash_ctl_properties.sv
// concurrent checks on the link between the cpu end and the device end.
// assumes one clock and an asynchronous active-low reset; pulses last one cycle.
`timescale 1ns/1ns
module flash_ctl_properties
	import flash_ctl_pkg::*;
(
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic [11:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic fetch_in_flash,
	input wire logic low_power,
	input wire logic flash_access,
	input wire logic irq_taken,
	input wire logic cmd_write,
	input wire logic [7:0] reg_rdata,
	input wire logic cmd_enable,
	input wire logic standby,
	input wire logic cutoff,
	input wire logic cmd_accept,
	input wire logic vector_fetch
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!reset_n_i);

	sequence key_write(k);
		reg_wr && reg_addr == WRITE_PROTECT_OFF && reg_wdata[7:4] == k;
	endsequence
	sequence irq_in_standby;
		irq_taken && standby;
	endsequence
	sequence cleared_then_vector;
		!standby && vector_fetch;
	endsequence
	sequence set_from_ram;
		reg_wr && reg_addr == STANDBY_OFF && reg_wdata[0] && !fetch_in_flash && !low_power
			&& !flash_access && !irq_taken;
	endsequence

	a_cmd_when_open: assert property (cmd_write && !reg_wr && cmd_enable |=> cmd_accept)
		else $error("command write refused while the key was open");
	a_cmd_when_shut: assert property (cmd_write && !cmd_enable |=> !cmd_accept)
		else $error("command write accepted while the key was shut");
	a_lock_key: assert property (key_write(KEY_LOCK) |=> !cmd_enable)
		else $error("lock value left commands enabled");
	a_unlock_key: assert property (key_write(KEY_ENABLE) |=> cmd_enable)
		else $error("unlock value did not enable commands");
	a_reset_locked: assert property ($rose(reset_n_i) |-> !cmd_enable && !standby)
		else $error("key or standby not at reset value");
	a_key_read_low: assert property (reg_rd && reg_addr == WRITE_PROTECT_OFF
		|=> reg_rdata[3:0] == LOW_NIBBLE_READ)
		else $error("control register low nibble not zero");
	a_standby_read: assert property (reg_rd && reg_addr == STANDBY_OFF
		|=> reg_rdata == STANDBY_READ)
		else $error("standby register read not zero");
	a_access_clears: assert property (flash_access |=> !standby)
		else $error("array access left standby set");
	a_irq_clears: assert property (irq_in_standby |=> cleared_then_vector)
		else $error("interrupt did not clear standby before vector fetch");
	a_halt_clears: assert property ($rose(low_power) |=> !standby)
		else $error("halt entry left standby set");
	a_halt_cutoff: assert property (low_power |=> cutoff)
		else $error("no cut-off in halt mode");
	a_run_cutoff: assert property (!low_power && standby && !fetch_in_flash
		&& !flash_access && !irq_taken && !reg_wr |=> cutoff)
		else $error("no cut-off with standby set in run mode");
	a_flash_set_ignored: assert property (reg_wr && reg_addr == STANDBY_OFF
		&& fetch_in_flash && !standby |=> !standby)
		else $error("standby set from code in flash");
	a_ram_set: assert property (set_from_ram |=> standby)
		else $error("standby write from ram ignored");
endmodule // flash_ctl_properties

// ### dv/flash_write_protect_standby_test.sv
// self-checking bench: axi4-lite master on the cpu end, device end across the link.
// assumes the package constants and a 125 MHz clock; reset held 20 cycles.
`timescale 1ns/1ns
module flash_write_protect_standby_test;
	import flash_ctl_pkg::*;
	logic clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, word;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [3:0] wstrb = 4'hf;
	logic cutoff_pin, enable_pin;
	int miscompares = 0;
	int comparisons = 0;
	flash_ctl_if link_if();
	always #4 clk_i = ~clk_i;
	flash_ctl_dev u_flash_ctl_dev(.clk_i(clk_i), .reset_n_i(reset_n_i), .link(link_if),
		.cutoff_o(cutoff_pin), .cmd_enable_o(enable_pin));
	flash_ctl_cpu u_flash_ctl_cpu(.clk_i(clk_i), .reset_n_i(reset_n_i), .link(link_if),
		.awaddr_i(awaddr), .awvalid_i(awvalid), .awready_o(awready), .wdata_i(wdata),
		.wstrb_i(wstrb), .wvalid_i(wvalid), .wready_o(wready), .bresp_o(bresp),
		.bvalid_o(bvalid), .bready_i(bready), .araddr_i(araddr), .arvalid_i(arvalid),
		.arready_o(arready), .rdata_o(rdata), .rresp_o(rresp), .rvalid_o(rvalid),
		.rready_i(rready));
	flash_ctl_properties u_flash_ctl_properties(.clk_i(clk_i), .reset_n_i(reset_n_i),
		.reg_addr(link_if.reg_addr), .reg_wdata(link_if.reg_wdata), .reg_wr(link_if.reg_wr),
		.reg_rd(link_if.reg_rd), .fetch_in_flash(link_if.fetch_in_flash),
		.low_power(link_if.low_power), .flash_access(link_if.flash_access),
		.irq_taken(link_if.irq_taken), .cmd_write(link_if.cmd_write),
		.reg_rdata(link_if.reg_rdata), .cmd_enable(link_if.cmd_enable),
		.standby(link_if.standby), .cutoff(link_if.cutoff), .cmd_accept(link_if.cmd_accept),
		.vector_fetch(link_if.vector_fetch));

	task automatic compare_word(input string what, input logic [31:0] exp, got);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic compare_resp(input string what, input logic [1:0] exp, got);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic compare_bit(input string what, input logic exp, got);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic complete_run;
		if (miscompares == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// handshakes are judged mid-cycle and acted on at the next rising edge
	task automatic axi_write(input logic [31:0] a, d, input logic [1:0] er);
		logic ha, hw, hb;
		@(posedge clk_i);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		bready <= 1'b1;
		hb = 1'b0;
		while (!hb) begin
			@(negedge clk_i);
			ha = awvalid & awready;
			hw = wvalid & wready;
			hb = (bvalid === 1'b1);
			if (hb) compare_resp("bresp", er, bresp);
			@(posedge clk_i);
			if (ha) awvalid <= 1'b0;
			if (hw) wvalid <= 1'b0;
			if (hb) bready <= 1'b0;
		end
	endtask
	task automatic axi_read(input logic [31:0] a, output logic [31:0] d, input logic [1:0] er);
		logic ha, hr;
		@(posedge clk_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		hr = 1'b0;
		while (!hr) begin
			@(negedge clk_i);
			ha = arvalid & arready;
			hr = (rvalid === 1'b1);
			d = rdata;
			if (hr) compare_resp("rresp", er, rresp);
			@(posedge clk_i);
			if (ha) arvalid <= 1'b0;
			if (hr) rready <= 1'b0;
		end
	endtask
	task automatic ctl_write(input logic [3:0] off, input logic [31:0] d, input logic [1:0] er);
		axi_write({28'h0000000, off}, d, er);
	endtask
	task automatic reg_write(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
		ctl_write(CTL_REG_ACCESS_OFF, {12'h000, a, d}, er);
	endtask
	task automatic reg_read(input logic [11:0] a);
		ctl_write(CTL_REG_ACCESS_OFF, {7'h00, 1'b1, 4'h0, a, 8'h00}, RESP_OKAY);
	endtask
	task automatic check_status(input logic [7:0] rd, input logic cut, en, st, f, lp,
		input logic [7:0] cc, vc);
		axi_read({28'h0000000, CTL_STATUS_OFF}, word, RESP_OKAY);
		compare_word("status", {vc, cc, 3'h0, lp, f, st, en, cut, rd}, word);
		compare_bit("cutoff pin", cut, cutoff_pin);
		compare_bit("enable pin", en, enable_pin);
	endtask

	task automatic check_reset_state;
		check_status(8'h00, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 8'h00, 8'h00);
		reg_read(WRITE_PROTECT_OFF);
		check_status(8'hc0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 8'h00, 8'h00);
	endtask
	task automatic check_key_gating;
		ctl_write(CTL_EVENT_OFF, 32'h0000_0004, RESP_OKAY);
		check_status(8'hc0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 8'h00, 8'h00);
		reg_write(WRITE_PROTECT_OFF, 8'h30, RESP_OKAY);
		reg_read(WRITE_PROTECT_OFF);
		ctl_write(CTL_EVENT_OFF, 32'h0000_0004, RESP_OKAY);
		check_status(8'h30, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 8'h01, 8'h00);
	endtask
	task automatic check_relock;
		reg_write(WRITE_PROTECT_OFF, 8'h58, RESP_SLVERR);
		check_status(8'h30, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 8'h01, 8'h00);
		reg_write(WRITE_PROTECT_OFF, 8'hc8, RESP_OKAY);
		ctl_write(CTL_EVENT_OFF, 32'h0000_0004, RESP_OKAY);
		check_status(8'h30, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 8'h01, 8'h00);
	endtask
	task automatic check_standby_set;
		reg_write(STANDBY_OFF, 8'h01, RESP_OKAY);
		check_status(8'h30, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 8'h01, 8'h00);
		ctl_write(CTL_MODE_OFF, 32'h0000_0000, RESP_OKAY);
		reg_write(STANDBY_OFF, 8'h01, RESP_OKAY);
		reg_read(STANDBY_OFF);
		check_status(8'h00, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 8'h01, 8'h00);
		ctl_write(CTL_EVENT_OFF, 32'h0000_0001, RESP_SLVERR);
		check_status(8'h00, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 8'h01, 8'h00);
	endtask
	task automatic check_irq;
		ctl_write(CTL_EVENT_OFF, 32'h0000_0002, RESP_OKAY);
		check_status(8'h00, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 8'h01, 8'h01);
	endtask
	task automatic check_low_power;
		reg_write(STANDBY_OFF, 8'h01, RESP_OKAY);
		ctl_write(CTL_MODE_OFF, 32'h0000_0002, RESP_OKAY);
		check_status(8'h00, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 8'h01, 8'h01);
		ctl_write(CTL_MODE_OFF, 32'h0000_0000, RESP_OKAY);
		ctl_write(CTL_EVENT_OFF, 32'h0000_0001, RESP_OKAY);
		check_status(8'h00, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 8'h01, 8'h01);
	endtask
	task automatic check_return;
		reg_write(STANDBY_OFF, 8'h01, RESP_OKAY);
		ctl_write(CTL_MODE_OFF, 32'h0000_0001, RESP_OKAY);
		check_status(8'h00, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 8'h01, 8'h01);
	endtask
	// a write with no byte lanes set carries a zero word into the mode register
	task automatic check_no_lanes;
		@(posedge clk_i);
		wstrb <= 4'h0;
		ctl_write(CTL_MODE_OFF, 32'h0000_0001, RESP_OKAY);
		wstrb <= 4'hf;
		check_status(8'h00, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 8'h01, 8'h01);
	endtask
	task automatic check_unmapped;
		axi_write(32'h0000_0010, 32'h0000_0001, RESP_SLVERR);
		axi_read({28'h0000000, CTL_EVENT_OFF}, word, RESP_SLVERR);
		compare_word("unmapped read", AXI_ZERO, word);
	endtask

	initial begin
		#100000;
		miscompares++;
		complete_run;
	end
	initial begin
		repeat (20) @(posedge clk_i);
		reset_n_i <= 1'b1;
		check_reset_state;
		check_key_gating;
		check_relock;
		check_standby_set;
		check_irq;
		check_low_power;
		check_return;
		check_no_lanes;
		check_unmapped;
		complete_run;
	end
endmodule // flash_write_protect_standby_test

// ### hdl/flash_ctl_cpu.sv
// cpu end: takes orders from software over axi4-lite and drives the link.
// assumes one write and one read at most in flight; link on the same clock.
`timescale 1ns/1ns
module flash_ctl_cpu
	import flash_ctl_pkg::*;
(
	input wire logic clk_i,
	input wire logic reset_n_i,
	flash_ctl_if.cpu link,
	input wire logic [31:0] awaddr_i,
	input wire logic awvalid_i,
	output logic awready_o,
	input wire logic [31:0] wdata_i,
	input wire logic [3:0] wstrb_i,
	input wire logic wvalid_i,
	output logic wready_o,
	output logic [1:0] bresp_o,
	output logic bvalid_o,
	input wire logic bready_i,
	input wire logic [31:0] araddr_i,
	input wire logic arvalid_i,
	output logic arready_o,
	output logic [31:0] rdata_o,
	output logic [1:0] rresp_o,
	output logic rvalid_o,
	input wire logic rready_i
);

	logic aw_rdy_reg, w_rdy_reg, bvalid_reg, ar_rdy_reg, rvalid_reg;
	logic [3:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [1:0] bresp_reg, rresp_reg;
	logic [31:0] rdata_reg;
	logic [11:0] addr_reg;
	logic [7:0] wd_reg;
	logic wr_reg, rd_reg, access_reg, irq_reg, cmdw_reg, fetch_reg, lp_reg;
	logic [7:0] cmd_count_reg, vec_count_reg;

	// only the lowest sixteen bytes of the window are decoded
	function automatic logic in_window(input logic [31:0] addr);
		return addr[31:4] == 28'h0;
	endfunction

	// the event counters wrap and read back as rolling totals
	function automatic logic [7:0] count_up(input logic [7:0] count);
		return count + 8'h01;
	endfunction

	wire logic aw_have = !aw_rdy_reg;
	wire logic w_have = !w_rdy_reg;
	wire logic do_write = aw_have && w_have && !bvalid_reg;
	wire logic [11:0] acc_addr = wdata_reg[ACC_ADDR_LSB +: ADDR_W];
	wire logic acc_read = wdata_reg[ACC_READ_BIT];
	wire logic [3:0] acc_key = wdata_reg[ACC_DATA_LSB + KEY_LSB +: KEY_W];
	wire logic key_legal = acc_key == KEY_LOCK || acc_key == KEY_ENABLE;
	wire logic to_protect = acc_addr == WRITE_PROTECT_OFF;
	wire logic acc_ok = acc_read || !to_protect || key_legal;
	wire logic [7:0] acc_data = to_protect
		? (wdata_reg[7:0] | 8'(1 << FORCED_ONE_BIT))
		: wdata_reg[7:0];
	wire logic ev_access = wdata_reg[EV_FLASH_ACCESS_BIT];
	wire logic ev_ok = !(ev_access && link.standby);
	wire logic new_fetch = wdata_reg[MODE_FETCH_FLASH_BIT];
	wire logic back_to_flash = new_fetch && !fetch_reg && link.standby;
	wire logic sel_acc = awaddr_reg == CTL_REG_ACCESS_OFF;
	wire logic sel_ev = awaddr_reg == CTL_EVENT_OFF;
	wire logic sel_mode = awaddr_reg == CTL_MODE_OFF;
	wire logic wr_ok = (sel_acc && acc_ok) || (sel_ev && ev_ok) || sel_mode;
	wire logic go_acc = do_write && sel_acc && acc_ok;
	wire logic go_ev = do_write && sel_ev && ev_ok;
	wire logic go_mode = do_write && sel_mode;
	wire logic lanes = wstrb_i != 4'h0;
	wire logic [3:0] ar_off = araddr_i[3:0];
	wire logic ar_status = ar_off == CTL_STATUS_OFF && in_window(araddr_i);
	wire logic [31:0] status_word = {vec_count_reg, cmd_count_reg, 3'h0,
		lp_reg, fetch_reg, link.standby, link.cmd_enable, link.cutoff,
		link.reg_rdata};

	// write address and data channels, taken in either order
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			aw_rdy_reg <= 1'b1;
			w_rdy_reg <= 1'b1;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
			awaddr_reg <= 4'h0;
			wdata_reg <= AXI_ZERO;
		end else begin
			if (awvalid_i && aw_rdy_reg) begin
				aw_rdy_reg <= 1'b0;
				awaddr_reg <= in_window(awaddr_i) ? awaddr_i[3:0] : 4'h3;
			end
			if (wvalid_i && w_rdy_reg) begin
				w_rdy_reg <= 1'b0;
				wdata_reg <= lanes ? wdata_i : AXI_ZERO;
			end
			if (do_write) begin
				bvalid_reg <= 1'b1;
				bresp_reg <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_reg && bready_i) begin
				bvalid_reg <= 1'b0;
				aw_rdy_reg <= 1'b1;
				w_rdy_reg <= 1'b1;
			end
		end
	end

	// link drive: one-cycle pulses with their address and data
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			addr_reg <= 12'h000;
			wd_reg <= 8'h00;
			wr_reg <= 1'b0;
			rd_reg <= 1'b0;
			access_reg <= 1'b0;
			irq_reg <= 1'b0;
			cmdw_reg <= 1'b0;
		end else begin
			wr_reg <= 1'b0;
			rd_reg <= 1'b0;
			access_reg <= 1'b0;
			irq_reg <= 1'b0;
			cmdw_reg <= 1'b0;
			if (go_acc) begin
				addr_reg <= acc_addr;
				wd_reg <= acc_data;
				wr_reg <= !acc_read;
				rd_reg <= acc_read;
			end
			if (go_ev) begin
				access_reg <= ev_access;
				irq_reg <= wdata_reg[EV_IRQ_BIT];
				cmdw_reg <= wdata_reg[EV_CMD_WRITE_BIT];
			end
			if (go_mode && back_to_flash) begin
				addr_reg <= STANDBY_OFF;
				wd_reg <= 8'h00;
				wr_reg <= 1'b1;
			end
		end
	end

	// held mode levels; code starts out running from the flash array
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			fetch_reg <= 1'b1;
			lp_reg <= 1'b0;
		end else begin
			if (go_mode) begin
				fetch_reg <= new_fetch;
				lp_reg <= wdata_reg[MODE_LOW_POWER_BIT];
			end
		end
	end

	// event counters fed by the device's one-cycle answers
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cmd_count_reg <= 8'h00;
			vec_count_reg <= 8'h00;
		end else begin
			if (link.cmd_accept) begin
				cmd_count_reg <= count_up(cmd_count_reg);
			end
			if (link.vector_fetch) begin
				vec_count_reg <= count_up(vec_count_reg);
			end
		end
	end

	// read channel: only the status word is readable
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ar_rdy_reg <= 1'b1;
			rvalid_reg <= 1'b0;
			rdata_reg <= AXI_ZERO;
			rresp_reg <= RESP_OKAY;
		end else begin
			if (arvalid_i && ar_rdy_reg) begin
				ar_rdy_reg <= 1'b0;
				rvalid_reg <= 1'b1;
				rdata_reg <= ar_status ? status_word : AXI_ZERO;
				rresp_reg <= ar_status ? RESP_OKAY : RESP_SLVERR;
			end else if (rvalid_reg && rready_i) begin
				rvalid_reg <= 1'b0;
				ar_rdy_reg <= 1'b1;
			end
		end
	end

	assign link.reg_addr = addr_reg;
	assign link.reg_wdata = wd_reg;
	assign link.reg_wr = wr_reg;
	assign link.reg_rd = rd_reg;
	assign link.flash_access = access_reg;
	assign link.irq_taken = irq_reg;
	assign link.cmd_write = cmdw_reg;
	assign link.fetch_in_flash = fetch_reg;
	assign link.low_power = lp_reg;
	assign awready_o = aw_rdy_reg;
	assign wready_o = w_rdy_reg;
	assign bvalid_o = bvalid_reg;
	assign bresp_o = bresp_reg;
	assign arready_o = ar_rdy_reg;
	assign rvalid_o = rvalid_reg;
	assign rdata_o = rdata_reg;
	assign rresp_o = rresp_reg;

endmodule // flash_ctl_cpu

// ### hdl/flash_ctl_dev.sv
// flash control device end: write-protect key and standby current cut-off.
// assumes the cpu end drives the link on clk_i; pulses last one cycle.
`timescale 1ns/1ns
module flash_ctl_dev
	import flash_ctl_pkg::*;
(
	input wire logic clk_i,
	input wire logic reset_n_i,
	flash_ctl_if.dev link,
	output logic cutoff_o,
	output logic cmd_enable_o
);

	logic [3:0] key_reg;
	logic [3:0] key_next;
	logic standby_reg;
	logic standby_next;
	logic low_power_reg;
	logic cutoff_reg;
	logic cutoff_next;
	logic cmd_enable_reg;
	logic cmd_accept_reg;
	logic vector_fetch_reg;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;

	wire logic hit_protect = link.reg_addr == WRITE_PROTECT_OFF;
	wire logic hit_standby = link.reg_addr == STANDBY_OFF;
	wire logic wr_protect = link.reg_wr && hit_protect;
	wire logic wr_standby = link.reg_wr && hit_standby;
	wire logic new_cutoff_bit = link.reg_wdata[CUTOFF_BIT];
	wire logic low_power_entry = link.low_power && !low_power_reg;

	// hardware clear takes precedence over a set written in the same cycle
	wire logic standby_clear = link.flash_access
		|| link.irq_taken
		|| low_power_entry;

	// a set from code fetched out of the flash array is dropped
	wire logic standby_set_ok = !link.fetch_in_flash;

	always_comb begin
		key_next = key_reg;
		if (wr_protect) begin
			key_next = link.reg_wdata[KEY_LSB +: KEY_W];
		end
	end

	always_comb begin
		standby_next = standby_reg;
		if (standby_clear) begin
			standby_next = 1'b0;
		end else if (wr_standby) begin
			if (!new_cutoff_bit) begin
				standby_next = 1'b0;
			end else if (standby_set_ok) begin
				standby_next = 1'b1;
			end
		end
	end

	always_comb begin
		if (link.low_power) begin
			cutoff_next = 1'b1;
		end else begin
			cutoff_next = standby_next && !link.fetch_in_flash
				&& !link.flash_access;
		end
	end

	always_comb begin
		rdata_next = rdata_reg;
		if (link.reg_rd) begin
			if (hit_protect) begin
				rdata_next = {key_reg, LOW_NIBBLE_READ};
			end else begin
				rdata_next = STANDBY_READ;
			end
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			key_reg <= KEY_RESET;
			cmd_enable_reg <= 1'b0;
			standby_reg <= STANDBY_RESET;
			low_power_reg <= 1'b0;
			cutoff_reg <= 1'b0;
			rdata_reg <= 8'h00;
		end else begin
			key_reg <= key_next;
			cmd_enable_reg <= key_next == KEY_ENABLE;
			standby_reg <= standby_next;
			low_power_reg <= link.low_power;
			cutoff_reg <= cutoff_next;
			rdata_reg <= rdata_next;
		end
	end

	// a command bus write counts only while the key holds the enable pattern
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cmd_accept_reg <= 1'b0;
			vector_fetch_reg <= 1'b0;
		end else begin
			cmd_accept_reg <= link.cmd_write && key_reg == KEY_ENABLE;
			// vector fetch rises at the same edge at which standby is cleared
			vector_fetch_reg <= link.irq_taken;
		end
	end

	assign link.reg_rdata = rdata_reg;
	assign link.cmd_enable = cmd_enable_reg;
	assign link.standby = standby_reg;
	assign link.cutoff = cutoff_reg;
	assign link.cmd_accept = cmd_accept_reg;
	assign link.vector_fetch = vector_fetch_reg;
	assign cutoff_o = cutoff_reg;
	assign cmd_enable_o = cmd_enable_reg;

endmodule // flash_ctl_dev

// ### hdl/flash_ctl_if.sv
// register-level link between the cpu end and the flash control device end.
// assumes both ends run on the same clock; no crossing is needed.
`timescale 1ns/1ns
interface flash_ctl_if;
	import flash_ctl_pkg::*;

	// cpu to device
	logic [11:0] reg_addr;
	logic [7:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic fetch_in_flash;
	logic low_power;
	logic flash_access;
	logic irq_taken;
	logic cmd_write;
	// device to cpu
	logic [7:0] reg_rdata;
	logic cmd_enable;
	logic standby;
	logic cutoff;
	logic cmd_accept;
	logic vector_fetch;

	modport dev (
		input reg_addr, reg_wdata, reg_wr, reg_rd, fetch_in_flash, low_power,
		input flash_access, irq_taken, cmd_write,
		output reg_rdata, cmd_enable, standby, cutoff, cmd_accept, vector_fetch
	);

	modport cpu (
		output reg_addr, reg_wdata, reg_wr, reg_rd, fetch_in_flash, low_power,
		output flash_access, irq_taken, cmd_write,
		input reg_rdata, cmd_enable, standby, cutoff, cmd_accept, vector_fetch
	);
endinterface

// ### hdl/flash_ctl_pkg.sv
// constants shared by the flash control device end and the cpu end.
// assumes one clock, clk_i, at 125 MHz and one asynchronous active-low reset.
package flash_ctl_pkg;

	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;

	// device register map
	localparam logic [11:0] WRITE_PROTECT_OFF = 12'hfe8;
	localparam logic [11:0] STANDBY_OFF = 12'hfe9;

	// write-protect control fields
	localparam int KEY_LSB = 4;
	localparam int KEY_W = 4;
	localparam int FORCED_ONE_BIT = 3;
	localparam logic [3:0] KEY_ENABLE = 4'h3;
	localparam logic [3:0] KEY_LOCK = 4'hc;
	localparam logic [3:0] KEY_RESET = KEY_LOCK;
	localparam logic [3:0] LOW_NIBBLE_READ = 4'h0;

	// standby control fields
	localparam int CUTOFF_BIT = 0;
	localparam logic STANDBY_RESET = 1'b0;
	localparam logic [7:0] STANDBY_READ = 8'h00;

	// controller registers seen over axi4-lite (byte addresses)
	localparam logic [3:0] CTL_REG_ACCESS_OFF = 4'h0;
	localparam logic [3:0] CTL_EVENT_OFF = 4'h4;
	localparam logic [3:0] CTL_MODE_OFF = 4'h8;
	localparam logic [3:0] CTL_STATUS_OFF = 4'hc;

	// reg access word: data [7:0], address [19:8], read flag [24]
	localparam int ACC_DATA_LSB = 0;
	localparam int ACC_ADDR_LSB = 8;
	localparam int ACC_READ_BIT = 24;

	// event word bits
	localparam int EV_FLASH_ACCESS_BIT = 0;
	localparam int EV_IRQ_BIT = 1;
	localparam int EV_CMD_WRITE_BIT = 2;

	// mode word bits
	localparam int MODE_FETCH_FLASH_BIT = 0;
	localparam int MODE_LOW_POWER_BIT = 1;

	// status word fields
	localparam int ST_RDATA_LSB = 0;
	localparam int ST_CUTOFF_BIT = 8;
	localparam int ST_CMD_ENABLE_BIT = 9;
	localparam int ST_STANDBY_BIT = 10;
	localparam int ST_FETCH_FLASH_BIT = 11;
	localparam int ST_LOW_POWER_BIT = 12;
	localparam int ST_CMD_COUNT_LSB = 16;
	localparam int ST_VEC_COUNT_LSB = 24;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [31:0] AXI_ZERO = 32'h0000_0000;

endpackage
